// [hw/cvdsq_defs.vh]
`ifndef CVDSQ_DEFS_VH
`define CVDSQ_DEFS_VH

`define CVDSQ_NUM_DESC 4
`define CVDSQ_FIFO_DEPTH 4
`define CVDSQ_SAMPLE_W 10
`define CVDSQ_ACC_W 18

// register map: descriptor word offsets (paddr[3:2]), then byte addresses
`define CVDSQ_OFF_C1 2'h0
`define CVDSQ_OFF_C2 2'h1
`define CVDSQ_OFF_C3 2'h2
`define CVDSQ_OFF_T2 2'h3
`define CVDSQ_ADDR_CTRL 8'h40
`define CVDSQ_ADDR_STAT 8'h44
`define CVDSQ_ADDR_RPOS 8'h48
`define CVDSQ_ADDR_RNEG 8'h4C
`define CVDSQ_ADDR_RDESC 8'h50

`define CVDSQ_RST_DESC 32'h00000000
`define CVDSQ_MASK_C3 32'hCF0F7F7F
`define CVDSQ_MASK_T2 32'h7F7F7F7F

// descriptor fields
`define CVDSQ_F_TH 31:8
`define CVDSQ_F_OVS 7:0
`define CVDSQ_F_TXLAST 29:24
`define CVDSQ_F_TXFIRST 21:16
`define CVDSQ_F_RXLAST 13:8
`define CVDSQ_F_RXFIRST 5:0
`define CVDSQ_F_RUN 31:30
`define CVDSQ_B_BUF 27
`define CVDSQ_B_IRQEN 26
`define CVDSQ_B_SELF 25
`define CVDSQ_B_MUT 24
`define CVDSQ_B_DIVEN 19
`define CVDSQ_F_CAP 18:16
`define CVDSQ_F_SETTLE 14:8
`define CVDSQ_F_CHARGE 6:0
`define CVDSQ_F_POLW 30:24
`define CVDSQ_F_RESW 22:16
`define CVDSQ_F_CHNW 14:8
`define CVDSQ_F_CONVW 6:0

`define CVDSQ_RUN_OFF 2'b00
`define CVDSQ_RUN_ONCE 2'b01
`define CVDSQ_RUN_KEEP 2'b10
`define CVDSQ_RUN_LOOP 2'b11

// control and status bits
`define CVDSQ_B_GO 0
`define CVDSQ_B_STALL 1
`define CVDSQ_B_BUSY 0
`define CVDSQ_B_EMPTY 1
`define CVDSQ_B_FULL 2
`define CVDSQ_B_OVF 3
`define CVDSQ_B_MISS 4

`endif

// [hw/cvdsq_top.v]
`timescale 1ns/100ps
`include "cvdsq_defs.vh"

module cvdsq_top (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire conv_done,
  input wire [`CVDSQ_SAMPLE_W-1:0] conv_data,
  output reg conv_start,
  output wire [5:0] tx_index,
  output wire [3:0] tx_step,
  output wire tx_drive,
  output wire [5:0] rx_index,
  output wire [3:0] rx_step,
  output wire rx_drive,
  output wire charge_phase,
  output wire polarity,
  output wire buffer_to_converter,
  output wire divider_enable,
  output wire [2:0] divider_cap_select,
  output reg match_irq,
  output wire scan_busy
);

  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_PICK = 4'h1;
  localparam [3:0] ST_CHARGE = 4'h2;
  localparam [3:0] ST_SETTLE = 4'h3;
  localparam [3:0] ST_CONVERT = 4'h4;
  localparam [3:0] ST_POLAR = 4'h5;
  localparam [3:0] ST_RESAMP = 4'h6;
  localparam [3:0] ST_CMP = 4'h7;
  localparam [3:0] ST_CHAN = 4'h8;
  localparam [3:0] ST_NEXTD = 4'h9;

  function is_desc;
    input [7:0] a;
    begin
      is_desc = (a[7:6] == 2'b00) && (a[1:0] == 2'b00);
    end
  endfunction

  function [31:0] pick32;
    input [127:0] v;
    input [1:0] i;
    begin
      pick32 = v[i*32 +: 32];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // apb decode

  wire wr_en = psel & penable & pwrite;
  wire rd_access = psel & penable & ~pwrite;
  wire mapped = is_desc(paddr) || (paddr == `CVDSQ_ADDR_CTRL) ||
    (paddr == `CVDSQ_ADDR_STAT) || (paddr == `CVDSQ_ADDR_RPOS) ||
    (paddr == `CVDSQ_ADDR_RNEG) || (paddr == `CVDSQ_ADDR_RDESC);

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  wire ctrl_wr = wr_en && (paddr == `CVDSQ_ADDR_CTRL);
  wire stat_wr = wr_en && (paddr == `CVDSQ_ADDR_STAT);
  wire go = ctrl_wr && pwdata[`CVDSQ_B_GO];

  reg [3:0] state_q;
  reg [1:0] cur_q;
  reg run_clr_q;

  ////////////////////////////////////////////////////////////////////////////////
  // descriptor registers

  wire [127:0] c1_w;
  wire [127:0] c2_w;
  wire [127:0] c3_w;
  wire [127:0] t2_w;

  genvar g;
  generate
    for (g = 0; g < `CVDSQ_NUM_DESC; g = g + 1)
    begin : gen_desc
      reg [31:0] c1_q;
      reg [31:0] c2_q;
      reg [31:0] c3_q;
      reg [31:0] t2_q;
      wire hit = wr_en && is_desc(paddr) && (paddr[5:4] == g);
      assign c1_w[g*32 +: 32] = c1_q;
      assign c2_w[g*32 +: 32] = c2_q;
      assign c3_w[g*32 +: 32] = c3_q;
      assign t2_w[g*32 +: 32] = t2_q;
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          c1_q <= `CVDSQ_RST_DESC;
          c2_q <= `CVDSQ_RST_DESC;
          c3_q <= `CVDSQ_RST_DESC;
          t2_q <= `CVDSQ_RST_DESC;
        end
        else
        begin
          if (hit && paddr[3:2] == `CVDSQ_OFF_C1)
            c1_q <= pwdata;
          if (hit && paddr[3:2] == `CVDSQ_OFF_C2)
            c2_q <= pwdata;
          if (hit && paddr[3:2] == `CVDSQ_OFF_T2)
            t2_q <= pwdata & `CVDSQ_MASK_T2;
          // a software write in the same cycle wins over the hardware clear
          if (hit && paddr[3:2] == `CVDSQ_OFF_C3)
            c3_q <= pwdata & `CVDSQ_MASK_C3;
          else if (run_clr_q && cur_q == g)
            c3_q[`CVDSQ_F_RUN] <= `CVDSQ_RUN_OFF;
        end
      end
    end
  endgenerate

  wire [31:0] d1 = pick32(c1_w, cur_q);
  wire [31:0] d2 = pick32(c2_w, cur_q);
  wire [31:0] d3 = pick32(c3_w, cur_q);
  wire [31:0] d4 = pick32(t2_w, cur_q);

  ////////////////////////////////////////////////////////////////////////////////
  // results fifo

  reg [`CVDSQ_ACC_W-1:0] fpos_q [0:`CVDSQ_FIFO_DEPTH-1];
  reg [`CVDSQ_ACC_W-1:0] fneg_q [0:`CVDSQ_FIFO_DEPTH-1];
  reg [31:0] fdesc_q [0:`CVDSQ_FIFO_DEPTH-1];
  reg [2:0] wp_q;
  reg [2:0] rp_q;
  wire [2:0] fcount = wp_q - rp_q;
  wire fempty = (wp_q == rp_q);
  wire ffull = (fcount == 3'd4);
  wire pop = rd_access && (paddr == `CVDSQ_ADDR_RDESC) && !fempty;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rp_q <= 3'd0;
    else if (pop)
      rp_q <= rp_q + 3'd1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control and sticky status

  reg stall_q;
  reg ovf_q;
  reg miss_q;
  reg [3:0] match_q;
  reg [3:0] done_q;
  reg ovf_p_q;
  reg miss_p_q;
  reg hit_p_q;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stall_q <= 1'b0;
      ovf_q <= 1'b0;
      miss_q <= 1'b0;
      match_q <= 4'h0;
    end
    else
    begin
      if (ctrl_wr)
        stall_q <= pwdata[`CVDSQ_B_STALL];
      // set beats write-one-to-clear in the same cycle
      ovf_q <= (ovf_q & ~(stat_wr & pwdata[`CVDSQ_B_OVF])) | ovf_p_q;
      miss_q <= (miss_q & ~(stat_wr & pwdata[`CVDSQ_B_MISS])) | miss_p_q;
      match_q <= (match_q & ~({4{stat_wr}} & pwdata[15:12])) |
        ({4{hit_p_q}} & (4'h1 << cur_q));
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read data, captured in the setup phase

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel && !penable)
    begin
      prdata <= 32'h00000000;
      if (is_desc(paddr))
      begin
        case (paddr[3:2])
          `CVDSQ_OFF_C1: prdata <= pick32(c1_w, paddr[5:4]);
          `CVDSQ_OFF_C2: prdata <= pick32(c2_w, paddr[5:4]);
          `CVDSQ_OFF_C3: prdata <= pick32(c3_w, paddr[5:4]);
          default: prdata <= pick32(t2_w, paddr[5:4]);
        endcase
      end
      else if (paddr == `CVDSQ_ADDR_CTRL)
        prdata <= {30'h0, stall_q, 1'b0};
      else if (paddr == `CVDSQ_ADDR_STAT)
        prdata <= {14'h0, cur_q, match_q, done_q, fcount, miss_q, ovf_q,
          ffull, fempty, scan_busy};
      else if (paddr == `CVDSQ_ADDR_RPOS && !fempty)
        prdata <= {14'h0, fpos_q[rp_q[1:0]]};
      else if (paddr == `CVDSQ_ADDR_RNEG && !fempty)
        prdata <= {14'h0, fneg_q[rp_q[1:0]]};
      else if (paddr == `CVDSQ_ADDR_RDESC && !fempty)
        prdata <= fdesc_q[rp_q[1:0]];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // scan sequencer

  reg [6:0] tmr_q;
  reg [7:0] smp_q;
  reg pol_q;
  reg got_q;
  reg matched_q;
  reg [5:0] tx_q;
  reg [5:0] rx_q;
  reg [`CVDSQ_ACC_W-1:0] acc_pos_q;
  reg [`CVDSQ_ACC_W-1:0] acc_neg_q;

  wire [6:0] tx_next = {1'b0, tx_q} + {3'b000, d2[31:30], d2[23:22]} + 7'd1;
  wire [6:0] rx_next = {1'b0, rx_q} + {3'b000, d2[15:14], d2[7:6]} + 7'd1;
  wire [`CVDSQ_ACC_W-1:0] delta = acc_pos_q - acc_neg_q;
  wire [`CVDSQ_ACC_W-1:0] mag = delta[`CVDSQ_ACC_W-1] ? (~delta + 1'b1) : delta;
  wire hit_now = {6'h00, mag} >= d1[`CVDSQ_F_TH];
  wire [1:0] run_mode = d3[`CVDSQ_F_RUN];

  // every dwell timer is loaded with its field and leaves on zero
  task pair_start;
    begin
      pol_q <= 1'b0;
      smp_q <= 8'h00;
      acc_pos_q <= {`CVDSQ_ACC_W{1'b0}};
      acc_neg_q <= {`CVDSQ_ACC_W{1'b0}};
      tmr_q <= d3[`CVDSQ_F_CHARGE];
      state_q <= ST_CHARGE;
    end
  endtask

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= ST_IDLE;
      cur_q <= 2'd0;
      run_clr_q <= 1'b0;
      tmr_q <= 7'd0;
      smp_q <= 8'h00;
      pol_q <= 1'b0;
      got_q <= 1'b0;
      matched_q <= 1'b0;
      tx_q <= 6'd0;
      rx_q <= 6'd0;
      acc_pos_q <= {`CVDSQ_ACC_W{1'b0}};
      acc_neg_q <= {`CVDSQ_ACC_W{1'b0}};
      wp_q <= 3'd0;
      done_q <= 4'h0;
      conv_start <= 1'b0;
      match_irq <= 1'b0;
      ovf_p_q <= 1'b0;
      miss_p_q <= 1'b0;
      hit_p_q <= 1'b0;
    end
    else
    begin
      run_clr_q <= 1'b0;
      conv_start <= 1'b0;
      match_irq <= 1'b0;
      ovf_p_q <= 1'b0;
      miss_p_q <= 1'b0;
      hit_p_q <= 1'b0;
      if (tmr_q != 7'd0)
        tmr_q <= tmr_q - 7'd1;
      case (state_q)
        ST_IDLE:
        begin
          if (go)
          begin
            cur_q <= 2'd0;
            done_q <= 4'h0;
            state_q <= ST_PICK;
          end
        end
        ST_PICK:
        begin
          if (run_mode != `CVDSQ_RUN_OFF)
          begin
            tx_q <= d2[`CVDSQ_F_TXFIRST];
            rx_q <= d2[`CVDSQ_F_RXFIRST];
            matched_q <= 1'b0;
            pair_start;
          end
          else
            state_q <= ST_NEXTD;
        end
        ST_CHARGE:
          if (tmr_q == 7'd0)
          begin
            tmr_q <= d3[`CVDSQ_F_SETTLE];
            state_q <= ST_SETTLE;
          end
        ST_SETTLE:
          if (tmr_q == 7'd0)
          begin
            tmr_q <= d4[`CVDSQ_F_CONVW];
            got_q <= 1'b0;
            conv_start <= 1'b1;
            state_q <= ST_CONVERT;
          end
        ST_CONVERT:
        begin
          // a late end of conversion is lost and flagged
          if (conv_done && !got_q)
          begin
            got_q <= 1'b1;
            if (pol_q)
              acc_neg_q <= acc_neg_q + {8'h00, conv_data};
            else
              acc_pos_q <= acc_pos_q + {8'h00, conv_data};
          end
          if (tmr_q == 7'd0)
          begin
            miss_p_q <= ~got_q & ~conv_done;
            if (smp_q != d1[`CVDSQ_F_OVS])
            begin
              smp_q <= smp_q + 8'h01;
              tmr_q <= d4[`CVDSQ_F_RESW];
              state_q <= ST_RESAMP;
            end
            else if (!pol_q)
            begin
              pol_q <= 1'b1;
              smp_q <= 8'h00;
              tmr_q <= d4[`CVDSQ_F_POLW];
              state_q <= ST_POLAR;
            end
            else
              state_q <= ST_CMP;
          end
        end
        ST_POLAR, ST_RESAMP:
          if (tmr_q == 7'd0)
          begin
            tmr_q <= d3[`CVDSQ_F_CHARGE];
            state_q <= ST_CHARGE;
          end
        ST_CMP:
        begin
          if (hit_now)
          begin
            matched_q <= 1'b1;
            hit_p_q <= 1'b1;
            match_irq <= d3[`CVDSQ_B_IRQEN];
          end
          // all results queue when stall is clear, else only matches
          if (hit_now || !stall_q)
          begin
            if (ffull)
              ovf_p_q <= 1'b1;
            else
            begin
              fpos_q[wp_q[1:0]] <= acc_pos_q;
              fneg_q[wp_q[1:0]] <= acc_neg_q;
              fdesc_q[wp_q[1:0]] <= {tx_q[4:0], 1'b0, cur_q, rx_q[4:0], 1'b0,
                delta};
              wp_q <= wp_q + 3'd1;
            end
          end
          tmr_q <= d4[`CVDSQ_F_CHNW];
          state_q <= ST_CHAN;
        end
        ST_CHAN:
          if (tmr_q == 7'd0)
          begin
            // a pointer that would pass index 63 also counts as past the end
            if (!rx_next[6] && rx_q < d2[`CVDSQ_F_RXLAST])
            begin
              rx_q <= rx_next[5:0];
              pair_start;
            end
            else if (!tx_next[6] && tx_q < d2[`CVDSQ_F_TXLAST])
            begin
              tx_q <= tx_next[5:0];
              rx_q <= d2[`CVDSQ_F_RXFIRST];
              pair_start;
            end
            else
            begin
              done_q[cur_q] <= 1'b1;
              if (run_mode == `CVDSQ_RUN_ONCE)
              begin
                run_clr_q <= 1'b1;
                state_q <= ST_NEXTD;
              end
              else if (run_mode == `CVDSQ_RUN_LOOP)
              begin
                run_clr_q <= matched_q | hit_p_q;
                state_q <= (matched_q | hit_p_q) ? ST_NEXTD : ST_PICK;
              end
              else
                state_q <= ST_NEXTD;
            end
          end
        ST_NEXTD:
        begin
          if (cur_q == 2'd3)
            state_q <= ST_IDLE;
          else
          begin
            cur_q <= cur_q + 2'd1;
            state_q <= ST_PICK;
          end
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // electrode and converter steering

  wire measuring = (state_q != ST_IDLE) && (state_q != ST_PICK) &&
    (state_q != ST_NEXTD);
  wire divider_on = measuring & d3[`CVDSQ_B_DIVEN];

  assign scan_busy = (state_q != ST_IDLE);
  assign charge_phase = (state_q == ST_CHARGE) & divider_on;
  assign polarity = pol_q;
  assign tx_index = tx_q;
  assign rx_index = rx_q;
  assign tx_step = {d2[31:30], d2[23:22]};
  assign rx_step = {d2[15:14], d2[7:6]};
  assign tx_drive = charge_phase & d3[`CVDSQ_B_MUT];
  assign rx_drive = charge_phase & d3[`CVDSQ_B_SELF];
  assign buffer_to_converter = divider_on & d3[`CVDSQ_B_BUF];
  assign divider_enable = divider_on;
  assign divider_cap_select = divider_on ? d3[`CVDSQ_F_CAP] : 3'b000;

endmodule

// [sim/cvdsq_conv_model.sv]
`timescale 1ns/100ps
module cvdsq_conv_model (
  input wire pclk,
  input wire presetn,
  input wire conv_start,
  input wire polarity,
  input wire [7:0] lat,
  input wire [9:0] pos_val,
  input wire [9:0] neg_val,
  output reg conv_done,
  output reg [9:0] conv_data
);
  reg [7:0] cnt_q;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q <= 8'h00;
      conv_done <= 1'b0;
      conv_data <= 10'h000;
    end
    else
    begin
      conv_done <= 1'b0;
      // no stale sample between conversions
      conv_data <= ~conv_data;
      if (conv_start)
        cnt_q <= lat + 8'h01;
      else if (cnt_q == 8'h01)
      begin
        // a long lat breaks the conversion deadline on purpose
        conv_done <= 1'b1;
        conv_data <= polarity ? neg_val : pos_val;
        cnt_q <= 8'h00;
      end
      else if (cnt_q != 8'h00)
        cnt_q <= cnt_q - 8'h01;
    end
  end
endmodule

// [sim/cvdsq_monitor.sv]
`timescale 1ns/100ps
module cvdsq_monitor (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pslverr,
  input wire conv_start,
  input wire tx_drive,
  input wire rx_drive,
  input wire charge_phase,
  input wire buffer_to_converter,
  input wire divider_enable,
  input wire [2:0] divider_cap_select,
  input wire match_irq,
  input wire scan_busy
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////
  AST_START_PULSE: assert property (conv_start |=> !conv_start)
    else $error("conv_start longer than one cycle");
  AST_CONV_INSIDE: assert property (conv_start |-> scan_busy ##1 scan_busy)
    else $error("conversion outside a scan");
  AST_SETTLE_GAP: assert property (conv_start |-> !charge_phase && $past(!charge_phase))
    else $error("conversion without settle cycle");
  AST_IRQ_PULSE: assert property (match_irq |=> !match_irq)
    else $error("match_irq longer than one cycle");
  AST_IRQ_BUSY: assert property (match_irq |-> scan_busy)
    else $error("match_irq while idle");
  AST_TX_DRIVE: assert property (tx_drive |-> charge_phase && divider_enable)
    else $error("tx driven outside charge");
  AST_RX_DRIVE: assert property (rx_drive |-> charge_phase && divider_enable)
    else $error("rx driven outside charge");
  AST_CAP_OFF: assert property (!divider_enable |-> divider_cap_select == 3'h0)
    else $error("cap select while divider off");
  AST_BUF_ROUTE: assert property (buffer_to_converter |-> divider_enable && scan_busy)
    else $error("buffer routed while not measuring");
  AST_IDLE_QUIET: assert property (!scan_busy |-> !charge_phase && !divider_enable)
    else $error("divider active while idle");
  AST_SLVERR: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access phase");
  COV_CONV: cover property (conv_start);
  COV_IRQ: cover property (match_irq);
  COV_ERR: cover property (pslverr);
  COV_TX: cover property (tx_drive ##1 !tx_drive);
endmodule

bind cvdsq_top cvdsq_monitor i_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pslverr(pslverr), .conv_start(conv_start), .tx_drive(tx_drive),
  .rx_drive(rx_drive), .charge_phase(charge_phase), .divider_enable(divider_enable),
  .buffer_to_converter(buffer_to_converter), .divider_cap_select(divider_cap_select),
  .match_irq(match_irq), .scan_busy(scan_busy));

// [sim/tb.sv]
`timescale 1ns/100ps
`include "cvdsq_defs.vh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_errors++; \
  $display("[FAIL] %0t got %0h expected %0h", $time, a, e); end end
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, conv_done, conv_start;
  logic tx_drive, rx_drive, charge_phase, polarity, buffer_to_converter, divider_enable;
  logic match_irq, scan_busy, er, chk_on, e_mut, e_self, e_buf, lastpol;
  logic [7:0] paddr, lat;
  logic [31:0] pwdata, prdata, rd;
  logic [9:0] conv_data, pos_v, neg_v, p, q;
  logic [5:0] tx_index, rx_index, tf, rf;
  logic [3:0] tx_step, rx_step, e_ts, e_rs, fl;
  logic [2:0] divider_cap_select, e_cap;
  logic [6:0] st, ch, pw, rw, cn;
  logic [17:0] d;
  int n_errors, n_checks, cyc, n_conv, n_irq, gap, e_rg, e_pg, i, j, n, r;
  cvdsq_top i_cvdsq_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .conv_done(conv_done), .conv_data(conv_data),
    .conv_start(conv_start), .tx_index(tx_index), .tx_step(tx_step), .tx_drive(tx_drive),
    .rx_index(rx_index), .rx_step(rx_step), .rx_drive(rx_drive),
    .charge_phase(charge_phase), .polarity(polarity),
    .buffer_to_converter(buffer_to_converter), .divider_enable(divider_enable),
    .divider_cap_select(divider_cap_select), .match_irq(match_irq), .scan_busy(scan_busy));
  cvdsq_conv_model i_cvdsq_conv_model (.pclk(pclk), .presetn(presetn),
    .conv_start(conv_start), .polarity(polarity), .lat(lat), .pos_val(pos_v),
    .neg_val(neg_v), .conv_done(conv_done), .conv_data(conv_data));
  ////////////////////////////////////////////////////////////////////////////
  function logic [17:0] acc(input int k, input logic [9:0] v);
    acc = 18'((k + 1) * v);
  endfunction
  function logic [17:0] mag(input logic [17:0] x);
    mag = x[17] ? -x : x;
  endfunction
  function logic [31:0] c3f(input [1:0] m, input [3:0] f, input [3:0] dc, input [6:0] s, c);
    c3f = {m, 2'h0, f, 4'h0, dc, 1'b0, s, 1'b0, c};
  endfunction
  task conclude;
    begin
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  // called right after a rising edge; returns one idle edge later
  task apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    begin
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
        @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task desc(input int k, input logic [31:0] c1, c2, c3, t2);
    begin
      apb(1'b1, 8'(16 * k), c1);
      apb(1'b1, 8'(16 * k + 4), c2);
      apb(1'b1, 8'(16 * k + 8), c3);
      apb(1'b1, 8'(16 * k + 12), t2);
    end
  endtask
  task run;
    int k;
    begin
      n_conv = 0;
      n_irq = 0;
      apb(1'b1, `CVDSQ_ADDR_CTRL, 32'h00000001);
      for (k = 0; k < 20000 && scan_busy !== 1'b0; k++)
        @(posedge pclk);
      if (scan_busy !== 1'b0)
      begin
        n_errors++;
        $display("[FAIL] %0t scan did not finish", $time);
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc++;
    n_conv += conv_start;
    n_irq += match_irq;
    gap++;
    if (chk_on)
    begin
      `CHK(tx_drive, charge_phase & e_mut)
      `CHK(rx_drive, charge_phase & e_self)
      `CHK(buffer_to_converter, divider_enable & e_buf)
      if (divider_enable) `CHK(divider_cap_select, e_cap)
      if (tx_drive) `CHK(tx_step, e_ts)
      if (rx_drive) `CHK(rx_step, e_rs)
      if (charge_phase) `CHK(rx_index, rf)
      if (charge_phase) `CHK(6'(tx_index - tf) % (e_ts + 1), 0)
      if (conv_start && !lastpol && !polarity) `CHK(gap, e_rg)
      if (conv_start && !lastpol && polarity) `CHK(gap, e_pg)
    end
    if (conv_start)
    begin
      lastpol = polarity;
      gap = 0;
    end
    if (cyc == 30000)
    begin
      n_errors++;
      $display("[FAIL] %0t timeout", $time);
      conclude();
    end
  end
  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, lat, pos_v, neg_v, chk_on} = '0;
    lastpol = 1'b1;
    void'($urandom(28645));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h00, 32'h0);
    `CHK(rd, `CVDSQ_RST_DESC)
    apb(1'b1, 8'h18, 32'hFFFFFFFF);
    apb(1'b0, 8'h18, 32'h0);
    `CHK(rd, `CVDSQ_MASK_C3)
    apb(1'b1, 8'h18, 32'h0);
    apb(1'b1, 8'h1C, 32'hFFFFFFFF);
    apb(1'b0, 8'h1C, 32'h0);
    `CHK(rd, `CVDSQ_MASK_T2)
    apb(1'b0, 8'h60, 32'h0);
    `CHK({er, rd}, 33'h100000000)
    // random single-descriptor scans, tx strides 1, 2 and 16 (step fields 0, 1 and 15)
    for (i = 0; i < 3; i++)
    begin
      e_ts = (i == 2) ? 4'hF : 4'(i);
      n = $urandom % 4;
      {p, q, fl, e_cap, e_rs} = {10'($urandom), 10'($urandom), 4'($urandom), 7'($urandom)};
      fl[2] = 1'b1;
      {e_buf, e_self, e_mut} = {fl[3], fl[1:0]};
      {st, ch, pw, rw, cn} = {7'($urandom % 4), 7'($urandom % 4), 7'($urandom % 4),
        7'($urandom % 4), 7'($urandom % 4)};
      e_rg = 12 + rw + ch + st;
      e_pg = 12 + pw + ch + st;
      tf = 6'($urandom % 8);
      rf = 6'($urandom);
      d = acc(n, p) - acc(n, q);
      r = $urandom % 2;
      desc(0, {24'(mag(d) + r), 8'(n)}, {e_ts[3:2], 6'(tf + 2 * e_ts + 2), e_ts[1:0], tf,
        e_rs[3:2], rf, e_rs[1:0], rf}, c3f(2'b01, fl, {1'b1, e_cap}, st, ch),
        {1'b0, pw, 1'b0, rw, 1'b0, cn, 8'h08});
      pos_v <= p;
      neg_v <= q;
      lat <= 8'($urandom % 7);
      chk_on = 1'b1;
      run();
      chk_on = 1'b0;
      `CHK(n_conv, 6 * (n + 1))
      `CHK(n_irq, r ? 0 : 3)
      for (j = 0; j < 3; j++)
      begin
        apb(1'b0, `CVDSQ_ADDR_RPOS, 32'h0);
        `CHK(rd, {14'h0, acc(n, p)})
        apb(1'b0, `CVDSQ_ADDR_RNEG, 32'h0);
        `CHK(rd, {14'h0, acc(n, q)})
        apb(1'b0, `CVDSQ_ADDR_RDESC, 32'h0);
        `CHK(rd, {5'(tf + j * (e_ts + 1)), 3'h0, rf[4:0], 1'b0, d})
      end
      apb(1'b0, 8'h08, 32'h0);
      `CHK(rd[31:30], `CVDSQ_RUN_ONCE ^ 2'b01)
    end
    // one pair per descriptor: keep, off, loop without irq, once
    pos_v <= 10'h12C;
    neg_v <= 10'h064;
    lat <= 8'h00;
    for (i = 0; i < 4; i++)
      desc(i, 32'h00000100, {2'h0, 6'(i), 2'h0, 6'(i), 2'h0, 6'(i), 2'h0, 6'(i)},
        c3f(2'((i == 0) ? 2 : (i == 2) ? 3 : (i == 3) ? 1 : 0), {1'b0, i != 2, 2'b01},
        4'h8, 7'h0, 7'h0), 32'h00000008);
    run();
    `CHK(n_irq, 2)
    `CHK(n_conv, 6)
    for (i = 0; i < 4; i++)
    begin
      apb(1'b0, 8'(16 * i + 8), 32'h0);
      `CHK(rd[31:30], (i == 0) ? `CVDSQ_RUN_KEEP : `CVDSQ_RUN_OFF)
    end
    apb(1'b0, `CVDSQ_ADDR_STAT, 32'h0);
    `CHK({rd[11:8], rd[7:5]}, 7'b1101011)
    for (i = 0; i < 4; i++)
    begin
      apb(1'b0, `CVDSQ_ADDR_RDESC, 32'h0);
      if (i < 3) `CHK(rd[25:24], 2'((i == 0) ? 0 : i + 1))
    end
    `CHK(rd, 32'h0)
    // converter too slow for the conversion window
    desc(0, 32'hFFFFFF00, 32'h0, c3f(2'b01, 4'h5, 4'h8, 7'h0, 7'h0), 32'h00000002);
    lat <= 8'h05;
    run();
    `CHK(n_irq, 0)
    apb(1'b0, `CVDSQ_ADDR_STAT, 32'h0);
    `CHK(rd[4], 1'b1)
    apb(1'b1, `CVDSQ_ADDR_STAT, 32'h00000010);
    apb(1'b0, `CVDSQ_ADDR_STAT, 32'h0);
    `CHK(rd[4], 1'b0)
    conclude();
  end
endmodule
